// ---- hw/serial_mux_defines.svh ----
`ifndef SERIAL_MUX_DEFINES_SVH
`define SERIAL_MUX_DEFINES_SVH

// management register numbers and page select value
`define REG_PAGE      5'h1F
`define REG_CFG       5'h14
`define REG_CMD       5'h15
`define REG_DATA      5'h16
`define GPIO_PAGE     16'h0010
`define PAGE_RST      16'h0000

// config register fields
`define CFG_DEV_MSB   15
`define CFG_DEV_LSB   9
`define CFG_RATE_MSB  5
`define CFG_RATE_LSB  4
`define CFG_RSV_MSB   3
`define CFG_RSV_LSB   2
`define CFG_EN_MSB    1
`define CFG_EN_LSB    0

// command and status register fields
`define CMD_READY     15
`define CMD_NACK      12
`define CMD_RSV       11
`define CMD_PORT      10
`define CMD_TRIG      9
`define CMD_DIR       8
`define CMD_LOC_MSB   7
`define CMD_LOC_LSB   0

// data register fields
`define DATA_RD_MSB   15
`define DATA_RD_LSB   8
`define DATA_WR_MSB   7
`define DATA_WR_LSB   0

// reset values
`define DEV_ADDR_RST  7'h50
`define RATE_RST      2'h1
`define DIR_RST       1'b1

// serial clock periods and quarter-period counts on the link clock
`define LINK_PERIOD_NS 30
`define SCL_NS_50K     20000
`define SCL_NS_100K    10000
`define SCL_NS_400K    2500
`define SCL_NS_2M      500
`define QTR_CYC(t) (((t) / 4 + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)

`endif

// ---- hw/serial_mux_pkg.sv ----
package serial_mux_pkg;

  // link sequencer states, one-hot
  typedef enum logic [3:0] {
    L_IDLE  = 4'b0001,
    L_START = 4'b0010,
    L_BYTE  = 4'b0100,
    L_STOP  = 4'b1000
  } link_state_t;

  // transaction snapshot taken at launch, static while busy
  typedef struct packed {
    logic [6:0] dev;
    logic [1:0] rate;
    logic       port;
    logic       dir;
    logic [7:0] loc;
    logic [7:0] wr;
  } job_t;

endpackage

// ---- hw/sync_two_flop.sv ----
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  ////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always_comb begin
    next_s      = s;
    next_s.meta = async_in;
    next_s.held = s.meta;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.held;

endmodule

`default_nettype wire

// ---- hw/serial_mux_master.sv ----
// Contract
// - address byte top seven bits come from config bits 15:9
// - address byte bottom bit is zero, and one only in the read address byte sent after the restart
// - port enable bits hand their pins to the master, reset clear
// - ready flag at bit 15 shows the master can take a request
// - port select bit 10 picks the bus, reset zero
// - writing trigger bit 9 launches; hardware clears it when done
// - direction bit 8: one reads, zero writes; resets to one
// - location byte 7:0 addresses the slave register, reset zero
// - data bits 15:8 hold the byte returned by a read
// - data bits 7:0 hold the byte to write, reset zero
`timescale 1ns/1ps
`default_nettype none

`include "serial_mux_defines.svh"

module serial_mux_master (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        link_clock,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  output logic      [15:0] reg_rdata,
  output logic      [1:0]  port_active,
  input  wire logic [1:0]  scl_in,
  output logic      [1:0]  scl_out,
  output logic      [1:0]  scl_oe,
  input  wire logic [1:0]  sda_in,
  output logic      [1:0]  sda_out,
  output logic      [1:0]  sda_oe
);
  import serial_mux_pkg::*;

  typedef struct packed {
    logic [15:0] page;
    logic [6:0]  dev;
    logic [1:0]  rate;
    logic [1:0]  cfg_rsv;
    logic [1:0]  en;
    logic        cmd_rsv;
    logic        port;
    logic        trig;
    logic        dir;
    logic [7:0]  loc;
    logic [7:0]  rd;
    logic [7:0]  wr;
    logic        ready;
    logic        nack;
    logic        launch_tgl;
    logic        done_seen;
    logic [15:0] rdata;
    job_t        job;
  } sys_t;

  typedef struct packed {
    link_state_t st;
    logic [7:0]  qcnt;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [2:0]  step;
    logic [7:0]  sh;
    logic [7:0]  rxd;
    logic        nack;
    logic [1:0]  scl_oe;
    logic [1:0]  sda_oe;
    logic [1:0]  lo;
    logic        done_tgl;
    logic        launch_seen;
  } lnk_t;

  sys_t        s;
  sys_t        next_s;
  lnk_t        l;
  lnk_t        next_l;
  logic        done_sync;
  logic [6:0]  lsync;
  logic        done_edge;
  logic        page_ok;

  ////////////////////////////////////////////////////////////////////////
  // crossings: done toggle into the register domain, launch toggle,
  // port enables and both pin inputs into the link domain
  sync_two_flop #(.W(1)) u_sync_done (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (l.done_tgl),
    .sync_out (done_sync)
  );

  sync_two_flop #(.W(7)) u_sync_link (
    .clock    (link_clock),
    .nrst     (nrst),
    .async_in ({s.launch_tgl, s.en, scl_in, sda_in}),
    .sync_out (lsync)
  );

  ////////////////////////////////////////////////////////////////////////
  // register domain
  assign page_ok   = (s.page == `GPIO_PAGE);
  assign done_edge = (done_sync != s.done_seen);

  // register writes, launch and completion; reads answer one cycle later
  always_comb begin
    next_s = s;
    if (reg_write) begin
      if (reg_addr == `REG_PAGE) begin
        next_s.page = reg_wdata;
      end else if (page_ok) begin
        case (reg_addr)
          `REG_CFG: begin
            next_s.dev     = reg_wdata[`CFG_DEV_MSB:`CFG_DEV_LSB];
            next_s.rate    = reg_wdata[`CFG_RATE_MSB:`CFG_RATE_LSB];
            next_s.cfg_rsv = reg_wdata[`CFG_RSV_MSB:`CFG_RSV_LSB];
            next_s.en      = reg_wdata[`CFG_EN_MSB:`CFG_EN_LSB];
          end
          `REG_CMD: begin
            next_s.cmd_rsv = reg_wdata[`CMD_RSV];
            next_s.port    = reg_wdata[`CMD_PORT];
            next_s.dir     = reg_wdata[`CMD_DIR];
            next_s.loc     = reg_wdata[`CMD_LOC_MSB:`CMD_LOC_LSB];
            // a trigger while busy is dropped, the job in flight is kept
            if (reg_wdata[`CMD_TRIG] && s.ready) begin
              next_s.trig       = 1'b1;
              next_s.ready      = 1'b0;
              next_s.nack       = 1'b0;
              next_s.launch_tgl = ~s.launch_tgl;
              next_s.job.dev    = s.dev;
              next_s.job.rate   = s.rate;
              next_s.job.port   = reg_wdata[`CMD_PORT];
              next_s.job.dir    = reg_wdata[`CMD_DIR];
              next_s.job.loc    = reg_wdata[`CMD_LOC_MSB:`CMD_LOC_LSB];
              next_s.job.wr     = s.wr;
            end
          end
          `REG_DATA: begin
            next_s.wr = reg_wdata[`DATA_WR_MSB:`DATA_WR_LSB];
          end
          default: begin
          end
        endcase
      end
    end
    // link finished: byte and ack result are static once toggle lands
    if (done_edge) begin
      next_s.done_seen = done_sync;
      next_s.trig      = 1'b0;
      next_s.ready     = 1'b1;
      next_s.nack      = l.nack;
      if (s.job.dir) begin
        next_s.rd = l.rxd;
      end
    end
    next_s.rdata = 16'h0000;
    if (reg_addr == `REG_PAGE) begin
      next_s.rdata = s.page;
    end else if (page_ok) begin
      case (reg_addr)
        `REG_CFG:  next_s.rdata = {s.dev, 3'h0, s.rate, s.cfg_rsv, s.en};
        `REG_CMD:  next_s.rdata = {s.ready, 2'h0, s.nack, s.cmd_rsv,
                                   s.port, s.trig, s.dir, s.loc};
        `REG_DATA: next_s.rdata = {s.rd, s.wr};
        default:   next_s.rdata = 16'h0000;
      endcase
    end
  end

  // reset values: module memory address, 100k rate, read direction
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s       <= '0;
      s.page  <= `PAGE_RST;
      s.dev   <= `DEV_ADDR_RST;
      s.rate  <= `RATE_RST;
      s.dir   <= `DIR_RST;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata   = s.rdata;
  assign port_active = s.en;

  ////////////////////////////////////////////////////////////////////////
  // link domain sequencer
  function automatic logic [7:0] quarter(input logic [1:0] rate);
    case (rate)
      2'h0:    quarter = 8'(`QTR_CYC(`SCL_NS_50K));
      2'h1:    quarter = 8'(`QTR_CYC(`SCL_NS_100K));
      2'h2:    quarter = 8'(`QTR_CYC(`SCL_NS_400K));
      default: quarter = 8'(`QTR_CYC(`SCL_NS_2M));
    endcase
  endfunction

  // what each step of the sequence does for the given direction
  function automatic link_state_t action(input logic [2:0] step,
                                         input logic dir);
    if (!dir) begin
      action = (step == 3'd4) ? L_STOP : L_BYTE;
    end else begin
      case (step)
        3'd3:    action = L_START;
        3'd6:    action = L_STOP;
        default: action = L_BYTE;
      endcase
    end
  endfunction

  function automatic logic [7:0] byte_for(input logic [2:0] step,
                                          input job_t j);
    case (step)
      3'd1:    byte_for = {j.dev, 1'b0};
      3'd2:    byte_for = j.loc;
      3'd3:    byte_for = j.wr;
      3'd4:    byte_for = {j.dev, 1'b1};
      default: byte_for = 8'hFF;
    endcase
  endfunction

  logic [1:0] en_l;
  logic [1:0] scl_hi;
  logic [1:0] sda_hi;
  logic       sel;
  logic       rd_byte;
  logic       tick;
  logic       scl_want;
  logic       sda_want;

  assign en_l   = lsync[5:4];
  assign scl_hi = lsync[3:2];
  assign sda_hi = lsync[1:0];
  // job fields are read only while busy, when they cannot change
  assign sel     = s.job.port;
  assign rd_byte = s.job.dir && (l.step == 3'd5);
  // a released clock held low by the slave stretches the quarter
  assign tick = (l.qcnt == 8'h00) && (l.scl_oe[sel] || scl_hi[sel]);

  always_comb begin
    next_l   = l;
    scl_want = 1'b0;
    sda_want = 1'b0;
    if (l.st == L_IDLE) begin
      if (lsync[6] != l.launch_seen) begin
        next_l.launch_seen = lsync[6];
        next_l.st          = L_START;
        next_l.ph          = 2'h0;
        next_l.step        = 3'd0;
        next_l.nack        = 1'b0;
        next_l.qcnt        = quarter(s.job.rate);
      end
    end else if (l.qcnt != 8'h00) begin
      next_l.qcnt = l.qcnt - 8'h01;
    end else if (tick) begin
      next_l.qcnt = quarter(s.job.rate);
      next_l.ph   = l.ph + 2'h1;
      if (l.ph == 2'h3) begin
        case (l.st)
          L_START: begin
            next_l.step = l.step + 3'd1;
            next_l.st   = L_BYTE;
            next_l.bitn = 4'd0;
            next_l.sh   = byte_for(l.step + 3'd1, s.job);
          end
          L_BYTE: begin
            if (l.bitn != 4'd8) begin
              next_l.bitn = l.bitn + 4'd1;
              next_l.sh   = {l.sh[6:0], 1'b1};
              if (rd_byte) begin
                next_l.rxd = {l.rxd[6:0], sda_hi[sel]};
              end
            end else if (!rd_byte && sda_hi[sel]) begin
              next_l.nack = 1'b1;
              next_l.st   = L_STOP;
            end else begin
              next_l.step = l.step + 3'd1;
              next_l.st   = action(l.step + 3'd1, s.job.dir);
              next_l.bitn = 4'd0;
              next_l.sh   = byte_for(l.step + 3'd1, s.job);
            end
          end
          L_STOP: begin
            next_l.st       = L_IDLE;
            next_l.qcnt     = 8'h00;
            next_l.done_tgl = ~l.done_tgl;
          end
          default: next_l.st = L_IDLE;
        endcase
      end
    end
    // pin drive for the coming quarter; data only moves while clock is low, except at start and stop
    case (next_l.st)
      L_START: begin
        scl_want = (next_l.ph < 2'h2);
        sda_want = (next_l.ph == 2'h3);
      end
      L_BYTE: begin
        scl_want = (next_l.ph < 2'h2);
        sda_want = (next_l.bitn != 4'd8) && !next_l.sh[7] &&
                   !(s.job.dir && next_l.step == 3'd5);
      end
      L_STOP: begin
        scl_want = (next_l.ph < 2'h2);
        sda_want = (next_l.ph == 2'h1) || (next_l.ph == 2'h2);
      end
      default: begin
        scl_want = 1'b0;
        sda_want = 1'b0;
      end
    endcase
    next_l.scl_oe = 2'b00;
    next_l.sda_oe = 2'b00;
    next_l.lo     = 2'b00;
    if (en_l[sel]) begin
      next_l.scl_oe[sel] = scl_want;
      if (next_l.st != L_IDLE && next_l.ph == 2'h0) begin
        next_l.sda_oe[sel] = l.sda_oe[sel];
      end else begin
        next_l.sda_oe[sel] = sda_want;
      end
    end
  end

  always_ff @(posedge link_clock or negedge nrst) begin
    if (!nrst) begin
      l    <= '0;
      l.st <= L_IDLE;
    end else begin
      l <= next_l;
    end
  end

  assign scl_out = l.lo;
  assign sda_out = l.lo;
  assign scl_oe  = l.scl_oe;
  assign sda_oe  = l.sda_oe;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_launch;
    reg_write && page_ok && reg_addr == `REG_CMD &&
    reg_wdata[`CMD_TRIG] && s.ready;
  endsequence

  property p_launch_busy;
    @(posedge clock) disable iff (!nrst)
    s_launch |=> !s.ready && s.trig;
  endproperty
  a_launch_busy: assert property (p_launch_busy)
    else $error("ready did not fall on launch");

  property p_trig_clear;
    @(posedge clock) disable iff (!nrst)
    $rose(s.ready) |-> !s.trig && $past(s.trig);
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger not cleared as ready returned");

  property p_ready_cause;
    @(posedge clock) disable iff (!nrst)
    $rose(s.ready) |-> $past(done_edge);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready rose without completion");

  property p_rd_update;
    @(posedge clock) disable iff (!nrst)
    $changed(s.rd) |-> $rose(s.ready);
  endproperty
  a_rd_update: assert property (p_rd_update)
    else $error("read byte changed outside completion");

  sequence s_data_wr;
    reg_write && page_ok && reg_addr == `REG_DATA;
  endsequence

  property p_wr_store;
    @(posedge clock) disable iff (!nrst)
    s_data_wr |=> s.wr == $past(reg_wdata[7:0]);
  endproperty
  a_wr_store: assert property (p_wr_store)
    else $error("write byte not stored");

  // read-back only holds while the address stays on the data register
  sequence s_data_hold;
    reg_addr == `REG_DATA && !reg_write;
  endsequence

  property p_wr_readback;
    @(posedge clock) disable iff (!nrst)
    s_data_wr ##1 s_data_hold |=> s.rdata[7:0] == s.wr;
  endproperty
  a_wr_readback: assert property (p_wr_readback)
    else $error("write byte not read back");

  property p_pins_gated;
    @(posedge link_clock) disable iff (!nrst)
    (l.scl_oe | l.sda_oe) != 2'b00 |-> $past(en_l[sel]);
  endproperty
  a_pins_gated: assert property (p_pins_gated)
    else $error("pin driven on a disabled port");

  property p_addr_write;
    @(posedge link_clock) disable iff (!nrst)
    l.st == L_BYTE && l.step == 3'd1 && l.bitn == 4'd0 |->
      l.sh == {s.job.dev, 1'b0};
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("write address byte wrong");

  property p_addr_read;
    @(posedge link_clock) disable iff (!nrst)
    l.st == L_BYTE && l.step == 3'd4 && l.bitn == 4'd0 |->
      s.job.dir && l.sh == {s.job.dev, 1'b1};
  endproperty
  a_addr_read: assert property (p_addr_read)
    else $error("read address byte wrong");

  property p_nack_stop;
    @(posedge link_clock) disable iff (!nrst)
    l.st == L_BYTE && l.bitn == 4'd8 && l.ph == 2'h3 && tick &&
      !rd_byte && sda_hi[sel] |=> l.st == L_STOP && l.nack;
  endproperty
  a_nack_stop: assert property (p_nack_stop)
    else $error("missing ack did not end in stop");

endmodule

`default_nettype wire

// ---- tb/serial_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module serial_slave_model #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] MIX  = 8'h5A
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic stretch,
  output logic      scl_low,
  output logic      sda_low
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] loc;
  logic [7:0] last_addr;
  int         cnt;
  int         nbyte;
  logic       sel;
  logic       tx;

  // every location preset to a known, distinct byte
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ MIX;
    scl_low = 1'b0;
    sda_low = 1'b0;
    sel = 1'b0;
    tx = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // start or restart opens a frame, stop closes it
  always @(sda) begin
    if (scl === 1'b1) begin
      sel = !sda;
      tx = 1'b0;
      cnt = 0;
      nbyte = 0;
      sda_low = 1'b0;
    end
  end

  // shift in on the rising edge; a master nack ends our sending
  always @(posedge scl) begin
    if (sel) begin
      if (tx && cnt == 8 && sda) sel = 1'b0;
      if (!tx && cnt < 8) sh = {sh[6:0], sda};
      cnt++;
    end
  end

  // change sda only while scl is low, so no false start or stop
  always @(negedge scl) begin
    if (sel && cnt == 8) begin
      if (tx) sda_low = 1'b0;
      else if (nbyte == 0) begin
        last_addr = sh;
        sel = (sh[7:1] == ADDR);
        sda_low = sel;
        tx = sh[0];
      end else begin
        if (nbyte == 1) loc = sh;
        else mem[loc] = sh;
        sda_low = 1'b1;
      end
    end else if (sel && cnt == 9) begin
      cnt = 0;
      nbyte++;
      sh = mem[loc];
      sda_low = tx & ~sh[7];
    end else if (sel && tx) sda_low = ~sh[7 - cnt];
  end

  // a slow slave holds scl low after each fall
  always @(negedge scl) begin
    if (stretch) begin
      scl_low = 1'b1;
      #400;
      scl_low = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serial_mux_defines.svh"

module testbench;
  typedef struct {
    logic       port;
    logic       dir;
    logic       slow;
    logic [7:0] loc;
    logic [7:0] wd;
    logic [7:0] rd;
  } row_t;

  logic        clock;
  logic        nrst;
  logic        link_clock;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic [15:0] reg_rdata;
  logic [1:0]  port_active;
  logic [1:0]  scl_oe;
  logic [1:0]  sda_oe;
  logic [1:0]  scl_o;
  logic [1:0]  sda_o;
  logic [1:0]  s_scl;
  logic [1:0]  s_sda;
  logic [1:0]  scl_w;
  logic [1:0]  sda_w;
  logic        stretch;
  logic [15:0] v;
  logic [7:0]  la;
  logic [7:0]  m;
  row_t        rw;
  realtime     t0;
  int          per;
  int          n_fail;
  int          num_checks;
  int          qtr [4] = '{167, 84, 21, 5};
  logic [4:0]  ra [4] = '{`REG_CFG, `REG_CMD, `REG_DATA, 5'h17};
  logic [15:0] rv [4] = '{16'hA010, 16'h8100, 16'h0000, 16'h0000};
  row_t        rows [6] = '{
    '{0, 0, 0, 8'h10, 8'h3C, 8'h00}, '{0, 1, 0, 8'h10, 8'h00, 8'h3C},
    '{0, 1, 1, 8'hFF, 8'h00, 8'hA5}, '{1, 0, 0, 8'h00, 8'h81, 8'h00},
    '{1, 1, 0, 8'h00, 8'h00, 8'h81}, '{0, 1, 0, 8'h00, 8'h00, 8'h5A}};

  // open drain with pull-ups: low only where an enabled driver shows 0
  assign scl_w = ~((scl_oe & ~scl_o) | s_scl);
  assign sda_w = ~((sda_oe & ~sda_o) | s_sda);

  serial_mux_master dut (
    .clock(clock), .nrst(nrst), .link_clock(link_clock),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_rdata(reg_rdata), .port_active(port_active),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe));
  serial_slave_model #(.MIX(8'h5A)) p0 (.scl(scl_w[0]), .sda(sda_w[0]),
    .stretch(stretch), .scl_low(s_scl[0]), .sda_low(s_sda[0]));
  serial_slave_model #(.MIX(8'hC3)) p1 (.scl(scl_w[1]), .sda(sda_w[1]),
    .stretch(1'b0), .scl_low(s_scl[1]), .sda_low(s_sda[1]));

  // clocks; the link clock is offset so the two never line up
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #7.5;
    forever #15 link_clock = ~link_clock;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the address
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // three cycles suffice: both domains clear asynchronously
  task automatic do_reset();
    @(negedge clock);
    nrst = 1'b0;
    repeat (3) @(negedge clock);
    check({10'h0, port_active, scl_oe, sda_oe}, 16'h0000);
    nrst = 1'b1;
  endtask

  task automatic wait_ready();
    logic [15:0] c;
    for (int i = 0; i < 20000; i++) begin
      reg_rd(`REG_CMD, c);
      if (c[15] === 1'b1) return;
    end
    n_fail++;
    stop_test();
  endtask

  task automatic wait_scl(input logic lv);
    for (int i = 0; i < 40000; i++) begin
      @(posedge clock);
      if (scl_w[0] === lv) return;
    end
    n_fail++;
    stop_test();
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    stretch = 1'b0;
    do_reset();
    reg_rd(`REG_PAGE, v);
    check(v, 16'h0000);
    reg_wr(`REG_CFG, 16'h0003);
    reg_wr(`REG_PAGE, `GPIO_PAGE);
    foreach (ra[k]) begin
      reg_rd(ra[k], v);
      check(v, rv[k]);
    end
    reg_wr(`REG_CFG, 16'hA033);
    reg_rd(`REG_CFG, v);
    check(v, 16'hA033);
    check({14'h0, port_active}, 16'h0003);
    foreach (rows[k]) begin
      rw = rows[k];
      stretch = rw.slow;
      reg_wr(`REG_DATA, {8'h00, rw.wd});
      reg_wr(`REG_CMD, {5'h00, rw.port, 1'b1, rw.dir, rw.loc});
      reg_rd(`REG_CMD, v);
      check(v & 16'h8200, 16'h0200);
      wait_ready();
      reg_rd(`REG_CMD, v);
      check(v, {1'b1, 4'h0, rw.port, 1'b0, rw.dir, rw.loc});
      la = rw.port ? p1.last_addr : p0.last_addr;
      check({8'h00, la}, {8'h00, 7'h50, rw.dir});
      reg_rd(`REG_DATA, v);
      m = rw.port ? p1.mem[rw.loc] : p0.mem[rw.loc];
      if (rw.dir) check(v, {rw.rd, rw.wd});
      else check({8'h00, m}, {8'h00, rw.wd});
    end
    stretch = 1'b0;
    // read-only fields must ignore writes
    reg_wr(`REG_DATA, 16'hFFFF);
    reg_wr(`REG_CMD, 16'h0000);
    reg_rd(`REG_DATA, v);
    check(v, 16'h5AFF);
    reg_rd(`REG_CMD, v);
    check(v, 16'h8000);
    // a second trigger while busy is dropped; the job in flight keeps loc
    reg_wr(`REG_CMD, 16'h0221);
    reg_wr(`REG_CMD, 16'h0222);
    reg_rd(`REG_CMD, v);
    check(v, 16'h0222);
    wait_ready();
    check({8'h00, p0.mem[8'h21]}, 16'h00FF);
    check({8'h00, p0.mem[8'h22]}, 16'h0078);
    reg_rd(`REG_CMD, v);
    check(v, 16'h8022);
    // a slave that does not answer its address ends the job early
    reg_wr(`REG_CFG, 16'hA233);
    reg_wr(`REG_CMD, 16'h0200);
    wait_ready();
    reg_rd(`REG_CMD, v);
    check(v, 16'h9000);
    check({8'h00, p0.last_addr}, 16'h00A2);
    // port 1 disabled: its bus must stay untouched
    reg_wr(`REG_CFG, 16'hA031);
    check({14'h0, port_active}, 16'h0001);
    reg_wr(`REG_CMD, 16'h0600);
    wait_ready();
    check({8'h00, p1.last_addr}, 16'h00A1);
    // each rate: time one scl period, then reset in mid-frame
    for (int r = 0; r < 4; r++) begin
      do_reset();
      reg_wr(`REG_PAGE, `GPIO_PAGE);
      reg_wr(`REG_CFG, {7'h50, 3'h0, 2'(r), 4'h1});
      reg_wr(`REG_CMD, 16'h0200);
      wait_scl(1'b0);
      wait_scl(1'b1);
      wait_scl(1'b0);
      t0 = $realtime;
      wait_scl(1'b1);
      wait_scl(1'b0);
      per = int'(($realtime - t0) / 30.0);
      check(16'(per >= 4 * qtr[r] - 1 && per <= 4 * qtr[r] + 6), 16'h1);
    end
    do_reset();
    stop_test();
  end
endmodule
`default_nettype wire
